/* src/ovf_top.sv */
// Notes on behaviour
// - Sixteen-bit threshold register, word access, RW
// - Eight-bit response byte, byte access, RW
// - Every fault pulls alert low, sets flag
// - Action 00: keep running, ignore fault
// - Action 01: run for delay, then retry
// - Action 10: disable at once, then retry
// - Action 11: off while fault, auto resume
// - Retry 000: stay off until flag and fault cleared
// - Retry 1..6: that many attempts, then off
// - Retry 111: retry until disabled or shut
// - Delay equals count times ten milliseconds
// - Retry spacing equals count times 8.2 ms
`default_nettype none
module ovf_top import ovf_pkg::*; #(
  parameter int unsigned DELAY_CYC = DELAY_UNIT_CYC,
  parameter int unsigned RETRY_CYC = RETRY_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             host_alert_line_n_out,
  output logic             host_alert_line_n_oe,
  // Converter side
  input  wire logic [15:0] vin_level,
  input  wire logic        on_request,
  input  wire logic        other_fault,
  output logic             output_enable,
  output logic             ov_fault_flag
);
  typedef struct packed {
    logic [15:0] thr;
    logic [7:0]  act;
    logic        stat;
    logic        fault;
    ovf_state_t  state;
    logic [2:0]  attempts;
  } ovf_top_s_t;

  ovf_top_s_t  r_reg;
  ovf_top_s_t  r_next;
  logic        wr_stb;
  logic [7:0]  wr_cmd;
  logic [15:0] wr_data;
  logic [1:0]  wr_len;
  logic [15:0] rd_data;
  logic [7:0]  stat_byte;
  logic        fault_rise;
  logic        dly_start, dly_done;
  logic        rty_start, rty_done;
  logic [1:0]  action;
  logic [2:0]  retry;
  logic [2:0]  units;
  logic        retry_more;

  // ==========================================
  // Serial bus slave
  ovf_smb_slave u_bus (
    .clk     (clk),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr_stb  (wr_stb),
    .wr_cmd  (wr_cmd),
    .wr_data (wr_data),
    .wr_len  (wr_len),
    .rd_data (rd_data)
  );

  // ==========================================
  // Delay and retry timers
  ovf_unit_timer #(.UNIT_CYC(DELAY_CYC)) u_dly (
    .clk   (clk),
    .rst   (rst),
    .start (dly_start),
    .units (units),
    .done  (dly_done)
  );

  ovf_unit_timer #(.UNIT_CYC(RETRY_CYC)) u_rty (
    .clk   (clk),
    .rst   (rst),
    .start (rty_start),
    .units (units),
    .done  (rty_done)
  );

  // ==========================================
  // Field decode and read mux
  assign action = r_reg.act[ACT_HI:ACT_LO];
  assign retry  = r_reg.act[RETRY_HI:RETRY_LO];
  assign units  = r_reg.act[TIME_HI:TIME_LO];
  assign retry_more = (retry == RETRY_ALWAYS) || ({1'b0, r_reg.attempts} + 4'h1 < {1'b0, retry});

  always_comb begin
    stat_byte           = '0;
    stat_byte[STAT_BIT] = r_reg.stat;
    case (wr_cmd)
      CMD_THRESH: rd_data = r_reg.thr;
      CMD_ACTION: rd_data = {8'h00, r_reg.act};
      CMD_STATUS: rd_data = {8'h00, stat_byte};
      default:    rd_data = '0;
    endcase
  end

  // ==========================================
  // Registers, fault detect and response
  always_comb begin
    r_next    = r_reg;
    dly_start = 1'b0;
    rty_start = 1'b0;
    fault_rise = (vin_level > r_reg.thr) && !r_reg.fault;
    if (vin_level > r_reg.thr) begin
      r_next.fault = 1'b1;
    end else if (vin_level < r_reg.thr) begin
      r_next.fault = 1'b0;
    end
    if (wr_stb && wr_cmd == CMD_THRESH && wr_len == LEN_WORD) begin
      r_next.thr = wr_data;
    end
    if (wr_stb && wr_cmd == CMD_ACTION && wr_len == LEN_BYTE) begin
      r_next.act = wr_data[7:0];
    end
    if (wr_stb && wr_cmd == CMD_STATUS && wr_len == LEN_BYTE && wr_data[STAT_BIT]) begin
      r_next.stat = 1'b0;
    end
    if (fault_rise) begin
      r_next.stat = 1'b1;
    end
    case (r_reg.state)
      ST_RUN: begin
        if (fault_rise) begin
          case (action)
            ACT_IGNORE: r_next.state = ST_RUN;
            ACT_CONT: begin
              r_next.state = ST_CONT;
              dly_start    = 1'b1;
            end
            ACT_DISABLE: begin
              r_next.attempts = '0;
              r_next.state    = (retry == RETRY_NONE) ? ST_LATCH : ST_WAIT;
              rty_start       = (retry != RETRY_NONE);
            end
            default: r_next.state = ST_HOLD;
          endcase
        end
      end
      ST_CONT: begin
        if (dly_done) begin
          r_next.attempts = '0;
          if (!r_reg.fault) begin
            r_next.state = ST_RUN;
          end else if (retry == RETRY_NONE) begin
            r_next.state = ST_LATCH;
          end else begin
            r_next.state = ST_WAIT;
            rty_start    = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (!on_request || other_fault) begin
          r_next.state = ST_LATCH;
        end else if (rty_done) begin
          if (!r_reg.fault) begin
            r_next.state = ST_RUN;
          end else if (retry_more) begin
            r_next.attempts = r_reg.attempts + 3'h1;
            rty_start       = 1'b1;
          end else begin
            r_next.state = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        if (!r_reg.stat && !r_reg.fault) begin
          r_next.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!r_reg.fault) begin
          r_next.state = ST_RUN;
        end
      end
      default: r_next.state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{thr: THRESH_RST, act: ACTION_RST, state: ST_RUN, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs
  assign output_enable         = on_request && (r_reg.state == ST_RUN || r_reg.state == ST_CONT);
  assign ov_fault_flag         = r_reg.stat;
  assign host_alert_line_n_out = 1'b0;
  assign host_alert_line_n_oe  = r_reg.stat;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cont_entry_s;
    r_reg.state == ST_RUN && fault_rise && action == ACT_CONT;
  endsequence
  sequence cont_running_s;
    r_reg.state == ST_CONT && output_enable == on_request;
  endsequence

  thresh_write_a: assert property (wr_stb && wr_cmd == CMD_THRESH && wr_len == LEN_WORD
    |=> r_reg.thr == $past(wr_data))
    else $error("threshold not written");
  action_write_a: assert property (wr_stb && wr_cmd == CMD_ACTION && wr_len == LEN_BYTE
    |=> r_reg.act == $past(wr_data[7:0]))
    else $error("response byte not written");
  alert_on_fault_a: assert property (fault_rise |=> host_alert_line_n_oe && ov_fault_flag)
    else $error("fault did not raise alert");
  ignore_runs_a: assert property (r_reg.state == ST_RUN && fault_rise && action == ACT_IGNORE
    |=> r_reg.state == ST_RUN)
    else $error("ignored fault changed state");
  cont_delay_a: assert property (cont_entry_s |=> cont_running_s)
    else $error("continue mode did not keep running");
  disable_now_a: assert property (r_reg.state == ST_RUN && fault_rise && action == ACT_DISABLE
    |=> !output_enable)
    else $error("output not disabled at once");
  hold_clear_a: assert property (r_reg.state == ST_HOLD && !r_reg.fault
    |=> r_reg.state == ST_RUN)
    else $error("hold did not resume");
  no_retry_a: assert property (r_reg.state == ST_RUN && fault_rise && action == ACT_DISABLE
    && retry == RETRY_NONE |=> r_reg.state == ST_LATCH [*2])
    else $error("no-retry setting did not latch off");
  retry_limit_a: assert property (r_reg.state == ST_WAIT && on_request && !other_fault
    && rty_done && r_reg.fault && !retry_more |=> r_reg.state == ST_LATCH)
    else $error("retries exceeded the limit");
  retry_always_a: assert property (r_reg.state == ST_WAIT && on_request && !other_fault
    && rty_done && r_reg.fault && retry == RETRY_ALWAYS |=> r_reg.state == ST_WAIT)
    else $error("continuous retry stopped");
  fault_level_a: assert property (vin_level > r_reg.thr |=> r_reg.fault)
    else $error("fault not detected above threshold");

  // ==========================================
  // Response checks
  sequence wait_attempt_s;
    r_reg.state == ST_WAIT && on_request && !other_fault && rty_done && r_reg.fault;
  endsequence

  fault_clear_a: assert property (vin_level < r_reg.thr |=> !r_reg.fault)
    else $error("fault not cleared below threshold");
  hold_off_a: assert property (r_reg.state == ST_HOLD |-> !output_enable)
    else $error("output on while holding");
  stop_retry_a: assert property (r_reg.state == ST_WAIT && (!on_request || other_fault)
    |=> r_reg.state == ST_LATCH)
    else $error("retry did not stop on disable");
  retry_restart_a: assert property (wait_attempt_s ##0 retry_more |-> rty_start)
    else $error("retry timer not restarted");
  cont_act_a: assert property (r_reg.state == ST_CONT && dly_done && r_reg.fault
    && retry == RETRY_NONE |=> r_reg.state == ST_LATCH)
    else $error("fault after delay not acted on");
  flag_sticky_a: assert property (ov_fault_flag && !wr_stb |=> ov_fault_flag)
    else $error("fault flag dropped without clear");
  latch_off_a: assert property (r_reg.state == ST_LATCH |-> !output_enable)
    else $error("output on while latched off");
  latch_exit_a: assert property (r_reg.state == ST_LATCH && !r_reg.stat && !r_reg.fault
    |=> r_reg.state == ST_RUN)
    else $error("latch did not release after clear");
endmodule // ovf_top
`default_nettype wire

/* src/ovf_pkg.sv */
`default_nettype none
package ovf_pkg;
  // ==========================================
  // Command codes and device address
  localparam logic [7:0]  CMD_THRESH   = 8'h55;
  localparam logic [7:0]  CMD_ACTION   = 8'h56;
  localparam logic [7:0]  CMD_STATUS   = 8'h7C;
  localparam logic [6:0]  DEV_ADDR     = 7'h10;
  // ==========================================
  // Reset values and field positions
  localparam logic [15:0] THRESH_RST   = 16'hFFFF;
  localparam logic [7:0]  ACTION_RST   = 8'h80;
  localparam int          ACT_HI       = 7;
  localparam int          ACT_LO       = 6;
  localparam int          RETRY_HI     = 5;
  localparam int          RETRY_LO     = 3;
  localparam int          TIME_HI      = 2;
  localparam int          TIME_LO      = 0;
  localparam int          STAT_BIT     = 7;
  // ==========================================
  // Field encodings
  localparam logic [1:0]  ACT_IGNORE   = 2'h0;
  localparam logic [1:0]  ACT_CONT     = 2'h1;
  localparam logic [1:0]  ACT_DISABLE  = 2'h2;
  localparam logic [1:0]  ACT_HOLD     = 2'h3;
  localparam logic [2:0]  RETRY_NONE   = 3'h0;
  localparam logic [2:0]  RETRY_ALWAYS = 3'h7;
  localparam logic [1:0]  LEN_WORD     = 2'h2;
  localparam logic [1:0]  LEN_BYTE     = 2'h1;
  localparam logic [1:0]  LEN_MAX      = 2'h3;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [3:0]  BIT_DONE     = 4'h9;
  // ==========================================
  // Timing
  localparam int          CLK_MHZ      = 250;
  localparam int          DELAY_UNIT_US = 10000;
  localparam int          RETRY_UNIT_US = 8200;
  localparam int          DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
  localparam int          RETRY_UNIT_CYC = RETRY_UNIT_US * CLK_MHZ;
  // ==========================================
  // State types
  typedef enum logic [2:0] {ST_RUN, ST_CONT, ST_WAIT, ST_LATCH, ST_HOLD} ovf_state_t;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WDAT, PH_RDAT, PH_IGN} ovf_phase_t;
endpackage
`default_nettype wire

/* src/ovf_unit_timer.sv */
`default_nettype none
module ovf_unit_timer import ovf_pkg::*; #(
  parameter int unsigned UNIT_CYC = 1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic [2:0] units,
  output logic            done
);
  localparam logic [31:0] LAST_CYC = 32'(UNIT_CYC - 1);

  typedef struct packed {
    logic        busy;
    logic [31:0] cyc;
    logic [2:0]  left;
    logic        done;
  } ovf_tmr_s_t;

  ovf_tmr_s_t r_reg;
  ovf_tmr_s_t r_next;

  // ==========================================
  // Unit counter
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.busy = 1'b1;
      r_next.cyc  = '0;
      r_next.left = units;
    end else if (r_reg.busy) begin
      if (r_reg.left == 3'h0) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else if (r_reg.cyc == LAST_CYC) begin
        r_next.cyc  = '0;
        r_next.left = r_reg.left - 3'h1;
      end else begin
        r_next.cyc = r_reg.cyc + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  zero_units_a: assert property (start && units == 3'h0 |=> ##1 done)
    else $error("zero units did not finish at once");
  done_cause_a: assert property (done |-> $past(r_reg.busy) && $past(r_reg.left) == 3'h0)
    else $error("timer finished with units left");
endmodule // ovf_unit_timer
`default_nettype wire

/* src/ovf_smb_slave.sv */
`default_nettype none
module ovf_smb_slave import ovf_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Register side
  output logic             wr_stb,
  output logic [7:0]       wr_cmd,
  output logic [15:0]      wr_data,
  output logic [1:0]       wr_len,
  input  wire logic [15:0] rd_data
);
  typedef struct packed {
    logic       scl_s1, scl_s2, scl_d;
    logic       sda_s1, sda_s2, sda_d;
    ovf_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift, tx, cmd;
    logic [15:0] wbuf;
    logic [1:0] nbytes;
    logic       byte_idx, rw, nack, sda_low, wr_stb;
  } ovf_smb_s_t;

  ovf_smb_s_t r_reg;
  ovf_smb_s_t r_next;
  logic       scl_hi, start_c, stop_c, rise_c, fall_c;
  logic [7:0] rd_byte;

  // ==========================================
  // Bit and byte engine
  always_comb begin
    r_next        = r_reg;
    r_next.wr_stb = 1'b0;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d  = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d  = r_reg.sda_s2;
    scl_hi  = r_reg.scl_s2 && r_reg.scl_d;
    start_c = scl_hi && r_reg.sda_d && !r_reg.sda_s2;
    stop_c  = scl_hi && !r_reg.sda_d && r_reg.sda_s2;
    rise_c  = r_reg.scl_s2 && !r_reg.scl_d;
    fall_c  = !r_reg.scl_s2 && r_reg.scl_d;
    rd_byte = r_reg.byte_idx ? rd_data[15:8] : rd_data[7:0];
    if (start_c) begin
      r_next.phase    = PH_ADDR;
      r_next.bit_cnt  = '0;
      r_next.sda_low  = 1'b0;
      r_next.byte_idx = 1'b0;
    end else if (stop_c) begin
      r_next.wr_stb  = (r_reg.phase == PH_WDAT) && (r_reg.nbytes != 2'h0);
      r_next.phase   = PH_IDLE;
      r_next.sda_low = 1'b0;
    end else if (r_reg.phase != PH_IDLE && r_reg.phase != PH_IGN) begin
      if (rise_c) begin
        if (r_reg.bit_cnt < BIT_ACK) begin
          r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
        end else begin
          r_next.nack = r_reg.sda_s2;
        end
        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
      end else if (fall_c) begin
        if (r_reg.bit_cnt == BIT_ACK) begin
          r_next.sda_low = 1'b1;
          case (r_reg.phase)
            PH_ADDR: begin
              if (r_reg.shift[7:1] != DEV_ADDR) begin
                r_next.sda_low = 1'b0;
                r_next.phase   = PH_IGN;
              end
              r_next.rw = r_reg.shift[0];
            end
            PH_CMD: begin
              r_next.cmd    = r_reg.shift;
              r_next.nbytes = '0;
            end
            PH_WDAT: begin
              if (r_reg.nbytes == 2'h0) r_next.wbuf[7:0] = r_reg.shift;
              if (r_reg.nbytes == 2'h1) r_next.wbuf[15:8] = r_reg.shift;
              if (r_reg.nbytes != LEN_MAX) r_next.nbytes = r_reg.nbytes + 2'h1;
            end
            default: r_next.sda_low = 1'b0;
          endcase
        end else if (r_reg.bit_cnt == BIT_DONE) begin
          r_next.bit_cnt = '0;
          r_next.sda_low = 1'b0;
          case (r_reg.phase)
            PH_ADDR: r_next.phase = r_reg.rw ? PH_RDAT : PH_CMD;
            PH_CMD:  r_next.phase = PH_WDAT;
            PH_RDAT: if (r_reg.nack) r_next.phase = PH_IGN;
            default: r_next.phase = r_reg.phase;
          endcase
          if (r_next.phase == PH_RDAT) begin
            r_next.tx       = rd_byte;
            r_next.sda_low  = !rd_byte[7];
            r_next.byte_idx = !r_reg.byte_idx;
          end
        end else if (r_reg.phase == PH_RDAT) begin
          r_next.tx      = {r_reg.tx[6:0], 1'b0};
          r_next.sda_low = !r_reg.tx[6];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                 sda_d: 1'b1, phase: PH_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = r_reg.sda_low;
  assign wr_stb  = r_reg.wr_stb;
  assign wr_cmd  = r_reg.cmd;
  assign wr_data = r_reg.wbuf;
  assign wr_len  = r_reg.nbytes;
endmodule // ovf_smb_slave
`default_nettype wire

/* tb/ovf_host_model.sv */
`default_nettype none
module ovf_host_model import ovf_pkg::*; (
  // Serial bus pins
  output logic      scl_out,
  output logic      sda_pull,
  input  wire logic sda_level
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================
  // Bit level, 48 ns bus clock, idle high
  task automatic put_bit(input logic b);
    #12 sda_pull = ~b;
    #12 scl_out = 1'b1;
    #24 scl_out = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    #12 sda_pull = 1'b0;
    #12 scl_out = 1'b1;
    #12 b = sda_level;
    #12 scl_out = 1'b0;
  endtask

  task automatic start_cond();
    #12 sda_pull = 1'b0;
    #12 scl_out = 1'b1;
    #12 sda_pull = 1'b1;
    #12 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #12 sda_pull = 1'b1;
    #12 scl_out = 1'b1;
    #12 sda_pull = 1'b0;
    #48;
  endtask

  // ==========================================
  // Byte level
  task automatic put_byte(input logic [7:0] v, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(nack);
  endtask

  task automatic get_byte(input logic last, output logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      v[i] = b;
    end
    put_bit(last);
  endtask

  // ==========================================
  // Transactions
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] cmd,
                           input logic [7:0] data[$], output logic nack);
    logic n;
    start_cond();
    put_byte({addr, 1'b0}, nack);
    put_byte(cmd, n);
    nack = nack | n;
    foreach (data[i]) begin
      put_byte(data[i], n);
      nack = nack | n;
    end
    stop_cond();
  endtask

  task automatic read_reg(input logic [6:0] addr, input logic [7:0] cmd, input int nbytes,
                          output logic [7:0] got[$]);
    logic       n;
    logic [7:0] v;
    got = {};
    start_cond();
    put_byte({addr, 1'b0}, n);
    put_byte(cmd, n);
    start_cond();
    put_byte({addr, 1'b1}, n);
    for (int i = 0; i < nbytes; i++) begin
      get_byte(i == nbytes - 1, v);
      got.push_back(v);
    end
    stop_cond();
  endtask
endmodule // ovf_host_model
`default_nettype wire

/* tb/input_overvoltage_fault_response_tb_top.sv */
`default_nettype none
module input_overvoltage_fault_response_tb_top import ovf_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DLY = 10;
  localparam int RTY = 8;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl, host_pull, sda_line, sda_out, sda_oe, alert_out, alert_oe;
  logic [15:0] vin_level = 16'h0000;
  logic        on_request = 1'b1;
  logic        other_fault = 1'b0;
  logic        output_enable, ov_fault_flag;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc_cnt = 0;

  // ==========================================
  // Clock, wire, instances
  always #2 clk = ~clk;
  assign sda_line = ~host_pull & (~sda_oe | sda_out);

  ovf_top #(.DELAY_CYC(DLY), .RETRY_CYC(RTY)) i_ovf_top (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .host_alert_line_n_out(alert_out), .host_alert_line_n_oe(alert_oe),
    .vin_level(vin_level), .on_request(on_request), .other_fault(other_fault),
    .output_enable(output_enable), .ov_fault_flag(ov_fault_flag));

  ovf_host_model i_ovf_host_model (.scl_out(scl), .sda_pull(host_pull), .sda_level(sda_line));

  // ==========================================
  // Common tasks
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] b[$]);
    logic n;
    i_ovf_host_model.write_reg(DEV_ADDR, cmd, b, n);
    clks(1);
  endtask

  task automatic bit_chk(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic clear_and_resume();
    vin_level = 16'h0FFF;
    wr(CMD_STATUS, {8'h80});
    clks(4);
    bit_chk("flag cleared", ov_fault_flag, 1'b0);
    bit_chk("alert released", alert_oe, 1'b0);
    bit_chk("resumed", output_enable, 1'b1);
  endtask

  task automatic fault_case(input logic [7:0] act, input int drop, input int chk,
                            input logic exp_en);
    wr(CMD_ACTION, {act});
    vin_level = 16'h1001;
    clks(drop);
    vin_level = 16'h0FFF;
    clks(chk - drop);
    bit_chk("enable after retries", output_enable, exp_en);
    clear_and_resume();
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] got[$];
    logic       n;
    i_ovf_host_model.read_reg(DEV_ADDR, CMD_THRESH, 2, got);
    check("thresh reset", {got[1], got[0]}, THRESH_RST);
    i_ovf_host_model.read_reg(DEV_ADDR, CMD_ACTION, 1, got);
    check("action reset", {8'h00, got[0]}, {8'h00, ACTION_RST});
    wr(CMD_THRESH, {8'h34, 8'h12});
    i_ovf_host_model.read_reg(DEV_ADDR, CMD_THRESH, 2, got);
    check("thresh rw", {got[1], got[0]}, 16'h1234);
    wr(CMD_ACTION, {8'hA5});
    i_ovf_host_model.read_reg(DEV_ADDR, CMD_ACTION, 1, got);
    check("action rw", {8'h00, got[0]}, 16'h00A5);
    i_ovf_host_model.write_reg(7'h11, CMD_ACTION, {8'h00}, n);
    bit_chk("foreign address nack", n, 1'b1);
    wr(CMD_THRESH, {8'h00, 8'h10});
  endtask

  task automatic t_ignore();
    wr(CMD_ACTION, {8'h00});
    vin_level = 16'h1000;
    clks(4);
    bit_chk("equal no fault", ov_fault_flag, 1'b0);
    vin_level = 16'h1001;
    clks(3);
    bit_chk("flag set", ov_fault_flag, 1'b1);
    bit_chk("alert low", alert_oe, 1'b1);
    bit_chk("alert drives low", alert_out, 1'b0);
    clks(40);
    bit_chk("ignore keeps on", output_enable, 1'b1);
    on_request = 1'b0;
    clks(2);
    bit_chk("off request", output_enable, 1'b0);
    on_request = 1'b1;
    clear_and_resume();
  endtask

  task automatic t_disable();
    wr(CMD_ACTION, {8'h80});
    vin_level = 16'h1001;
    clks(3);
    bit_chk("disable at once", output_enable, 1'b0);
    bit_chk("alert on disable", alert_oe, 1'b1);
    vin_level = 16'h0FFF;
    clks(30);
    bit_chk("no retry stays off", output_enable, 1'b0);
    clear_and_resume();
  endtask

  task automatic t_hold();
    wr(CMD_ACTION, {8'hC0});
    vin_level = 16'h1001;
    clks(25);
    bit_chk("hold off", output_enable, 1'b0);
    vin_level = 16'h0FFF;
    clks(4);
    bit_chk("auto resume", output_enable, 1'b1);
    bit_chk("flag sticky", ov_fault_flag, 1'b1);
    clear_and_resume();
  endtask

  task automatic t_delay();
    wr(CMD_ACTION, {8'h42});
    vin_level = 16'h1001;
    clks(18);
    bit_chk("runs during delay", output_enable, 1'b1);
    clks(8);
    bit_chk("acts after delay", output_enable, 1'b0);
    clear_and_resume();
    fault_case(8'h42, 15, 40, 1'b1);
  endtask

  task automatic t_retry();
    fault_case(8'h89, 7, 22, 1'b1);
    fault_case(8'h89, 15, 30, 1'b0);
    fault_case(8'hB1, 57, 72, 1'b1);
    fault_case(8'hB1, 65, 80, 1'b0);
    fault_case(8'h92, 33, 50, 1'b1);
    fault_case(8'h92, 41, 55, 1'b0);
    fault_case(8'hBA, 150, 170, 1'b1);
  endtask

  task automatic t_endless_stop();
    wr(CMD_ACTION, {8'hB9});
    vin_level = 16'h1001;
    clks(25);
    other_fault = 1'b1;
    clks(3);
    other_fault = 1'b0;
    vin_level = 16'h0FFF;
    clks(40);
    bit_chk("endless retry stopped", output_enable, 1'b0);
    clear_and_resume();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    clks(4);
    t_regs();
    t_ignore();
    t_disable();
    t_hold();
    t_delay();
    t_retry();
    t_endless_stop();
    tally_and_finish();
  end
endmodule // input_overvoltage_fault_response_tb_top
`default_nettype wire
